// file: core/flash_prog_pkg.sv
// Constants, register map and types for the user-mode flash controller
package flash_prog_pkg;

  // ****************
  // Register map
  // ****************
  localparam int          ADDR_W        = 8;
  localparam logic [7:0]  OFS_UNLOCK    = 8'h00;
  localparam logic [7:0]  OFS_OPCTL     = 8'h04;
  localparam logic [7:0]  OFS_SEC_HI    = 8'h08;
  localparam logic [7:0]  OFS_SEC_LO    = 8'h0c;
  localparam logic [7:0]  OFS_TBL_ADDR  = 8'h10;
  localparam logic [7:0]  OFS_TBL_WDATA = 8'h14;
  localparam logic [7:0]  OFS_TBL_RDATA = 8'h18;
  localparam logic [7:0]  OFS_STATUS    = 8'h1c;

  // ****************
  // Field values
  // ****************
  localparam logic [7:0]  UNLOCK_KEY    = 8'ha5;
  localparam logic [7:0]  UNLOCK_RESET  = 8'h00;
  localparam logic [3:0]  MODE_ERASE    = 4'ha;
  localparam logic [3:0]  MODE_PROG     = 4'h5;
  localparam logic [3:0]  MODE_LOCK     = 4'h6;
  localparam int          START_BIT     = 0;
  localparam int          SEC_LO_BIT    = 7;

  // ****************
  // Option byte decode
  // ****************
  localparam int          OPT_VEC_OFF   = 7;
  localparam int          OPT_SIZE_OFF  = 2;
  localparam logic [15:0] REGION_BASE   = 16'h0100;
  localparam logic [15:0] REGION_END0   = 16'h01ff;
  localparam logic [15:0] REGION_END1   = 16'h02ff;
  localparam logic [15:0] REGION_END2   = 16'h04ff;
  localparam logic [15:0] REGION_END3   = 16'h08ff;
  localparam logic [15:0] VEC_DEFAULT   = 16'h0100;
  localparam logic [15:0] VEC_SEL0      = 16'h0200;
  localparam logic [15:0] VEC_SEL1      = 16'h0300;
  localparam logic [15:0] VEC_SEL2      = 16'h0500;
  localparam logic [15:0] VEC_SEL3      = 16'h0900;

  // ****************
  // Timing
  // ****************
  localparam int          CLK_FREQ_MHZ  = 200;
  localparam int          ERASE_TIME_MS = 10;
  localparam int          ERASE_CYC_DEF = ERASE_TIME_MS * 1000 * CLK_FREQ_MHZ;
  localparam int          CNT_W         = 22;

  typedef enum logic [0:0] {
    ST_IDLE  = 1'b0,
    ST_ERASE = 1'b1
  } fstate_t;

endpackage

// file: core/opt_decode.sv
// Option byte decode: protected region bounds and reset vector
module opt_decode
  import flash_prog_pkg::*;
(
  input  wire logic [7:0]  opt,
  output logic             region_en,
  output logic [15:0]      region_end,
  output logic [15:0]      reset_vec
);

  // R04 region size select
  always_comb begin
    region_en  = ~opt[OPT_SIZE_OFF];
    case (opt[OPT_SIZE_OFF-1 -: 2])
      2'h0:    region_end = REGION_END0;
      2'h1:    region_end = REGION_END1;
      2'h2:    region_end = REGION_END2;
      default: region_end = REGION_END3;
    endcase
  end

  // R06 vector decoded apart from size
  always_comb begin
    if (opt[OPT_VEC_OFF]) begin
      reset_vec = VEC_DEFAULT;
    end else begin
      // R05 vector select codes
      case (opt[OPT_VEC_OFF-1 -: 2])
        2'h0:    reset_vec = VEC_SEL0;
        2'h1:    reset_vec = VEC_SEL1;
        2'h2:    reset_vec = VEC_SEL2;
        default: reset_vec = VEC_SEL3;
      endcase
    end
  end

endmodule

// file: core/flash_user_program_ctrl.sv
// User-mode flash erase, program, read and lock controller on AHB-Lite
//
// Summary of operation
// R01: Protected region refuses user erase and program
// R02: Region exists only when enable bit is 0
// R03: Tool mode may still alter protected region
// R04: Option bits 2..0 select region size
// R05: Option bits 7..5 select reset vector
// R06: Vector and size fields decode independently
// R07: Sector erase only in user mode
// R08: 512 sectors of 128 bytes each
// R09: Software erases a sector before programming it
// R10: Erase lasts 10 ms; sector untouched meanwhile
// R11: Software follows unlock, address, start, relock
// R12: Status bit 3 reports erase failure
// R13: Software idles after starting an operation
// R14: One byte per table write within sector
// R15: Program mode writes table data to address
// R16: Table read works without unlocking
// R17: Mode 0110 with start sets permanent lock
// R18: Only tool chip erase clears the lock
// R19: Unlock register resets to zero; key A5
// R20: Interrupt aborts erase and flags failure
// R21: Bit 0 starts erase and lock only
// R22: Low sector bits 6..0 are ignored
// R23: Refused writes leave flash contents unchanged
//
// The register offsets and the AHB-Lite register port were chosen for this implementation.
module flash_user_program_ctrl
  import flash_prog_pkg::*;
#(
  parameter int unsigned ERASE_CYCLES = ERASE_CYC_DEF
)(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [7:0]  option_byte,
  input  wire logic        tool_mode,
  input  wire logic        emulator_mode,
  input  wire logic        irq_request,
  input  wire logic        chip_erase,
  input  wire logic [7:0]  flash_rdata,
  output logic      [15:0] flash_addr,
  output logic      [7:0]  flash_wdata,
  output logic             flash_prog,
  output logic             flash_erase,
  output logic      [15:0] reset_vector,
  output logic             lock_active,
  output logic             erase_busy
);

  // ****************
  // State
  // ****************
  typedef struct packed {
    logic [7:0]       opt_s1;
    logic [7:0]       opt_s2;
    logic [1:0]       mode_s1;
    logic [1:0]       mode_s2;
    logic             ap_valid;
    logic             ap_write;
    logic [7:0]       ap_addr;
    logic [31:0]      hrdata;
    logic             hreadyout;
    logic [7:0]       unlock;
    logic [3:0]       mode;
    logic             status;
    logic [7:0]       sec_hi;
    logic             sec_lo;
    logic [15:0]      tbl_addr;
    logic             lock;
    fstate_t          state;
    logic [CNT_W-1:0] cnt;
    logic [15:0]      flash_addr;
    logic [7:0]       flash_wdata;
    logic             flash_prog;
    logic             flash_erase;
    logic [15:0]      reset_vector;
  } ctrl_state_t;

  localparam ctrl_state_t CTRL_RESET = '{
    hreadyout:    1'b1,
    unlock:       UNLOCK_RESET,
    state:        ST_IDLE,
    reset_vector: VEC_DEFAULT,
    default:      '0
  };

  localparam logic [CNT_W-1:0] ERASE_LAST = CNT_W'(ERASE_CYCLES - 1);

  ctrl_state_t s_reg;
  ctrl_state_t s_next;

  logic        region_en;
  logic [15:0] region_end;
  logic [15:0] dec_vec;

  opt_decode u_opt (
    .opt        (s_reg.opt_s2),
    .region_en  (region_en),
    .region_end (region_end),
    .reset_vec  (dec_vec)
  );

  // ****************
  // Derived conditions
  // ****************
  logic        in_tool;
  logic        in_emu;
  logic        unlocked;
  logic        user_ok;
  logic        prot_on;
  logic [15:0] sec_base;
  logic        sec_prot;
  logic        addr_prot;
  logic        same_sector;
  logic [7:0]  wbyte;

  assign in_tool = s_reg.mode_s2[1];
  assign in_emu  = s_reg.mode_s2[0];

  // R19 key compare
  assign unlocked = (s_reg.unlock == UNLOCK_KEY);
  // R23 unlock, no lock, user mode
  assign user_ok  = unlocked & ~s_reg.lock & ~in_tool & ~in_emu;

  // R02 region only when enabled
  // R03 tool mode bypasses region
  assign prot_on = region_en & ~in_tool;

  // R08 R22 sector base from 9 bits
  assign sec_base = {s_reg.sec_hi, s_reg.sec_lo, {SEC_LO_BIT{1'b0}}};

  // R01 region overlap checks
  assign sec_prot  = prot_on && (sec_base >= REGION_BASE) && (sec_base <= region_end);
  assign addr_prot = prot_on && (s_reg.tbl_addr >= REGION_BASE)
                     && (s_reg.tbl_addr <= region_end);

  // R14 write must fall in loaded sector
  assign same_sector = (s_reg.tbl_addr[15:SEC_LO_BIT] == {s_reg.sec_hi, s_reg.sec_lo});

  assign wbyte = hwdata[7:0];

  // ****************
  // Next state
  // ****************
  always_comb begin
    logic [31:0] rd;
    rd = '0;
    s_next = s_reg;
    s_next.flash_prog = 1'b0;

    // Option and mode pin levels pass two stages before use; irq_request and chip_erase are used directly
    s_next.opt_s1  = option_byte;
    s_next.opt_s2  = s_reg.opt_s1;
    s_next.mode_s1 = {tool_mode, emulator_mode};
    s_next.mode_s2 = s_reg.mode_s1;
    s_next.reset_vector = dec_vec;

    // Read mux for the address phase
    case (haddr[ADDR_W-1:0])
      OFS_UNLOCK:    rd = {24'h0000_00, s_reg.unlock};
      OFS_OPCTL:     rd = {24'h0000_00, s_reg.mode, s_reg.status, 2'b00,
                           (s_reg.state == ST_ERASE)};
      OFS_SEC_HI:    rd = {24'h0000_00, s_reg.sec_hi};
      OFS_SEC_LO:    rd = {24'h0000_00, s_reg.sec_lo, {SEC_LO_BIT{1'b0}}};
      OFS_TBL_ADDR:  rd = {16'h0000, s_reg.tbl_addr};
      // R16 table read needs no unlock
      OFS_TBL_RDATA: rd = {24'h0000_00, flash_rdata};
      OFS_STATUS:    rd = {s_reg.reset_vector, 13'h0000, region_en,
                           (s_reg.state == ST_ERASE), s_reg.lock};
      default:       rd = '0;
    endcase

    if (hready) begin
      s_next.ap_valid = hsel & htrans[1];
      s_next.ap_write = hwrite;
      s_next.ap_addr  = haddr[ADDR_W-1:0];
      s_next.hrdata   = (hsel & htrans[1] & ~hwrite) ? rd : '0;
    end

    // ****************
    // Register writes in the data phase
    // ****************
    if (s_reg.ap_valid && s_reg.ap_write) begin
      case (s_reg.ap_addr)
        OFS_UNLOCK: begin
          s_next.unlock = wbyte;
        end
        OFS_OPCTL: begin
          // Control changes only while unlocked and idle
          if (unlocked && s_reg.state == ST_IDLE) begin
            s_next.mode = wbyte[7:4];
            // R21 start bit triggers erase and lock
            if (wbyte[START_BIT]) begin
              case (wbyte[7:4])
                MODE_ERASE: begin
                  // R07 R01 R23 erase gate
                  if (user_ok && !sec_prot) begin
                    s_next.state       = ST_ERASE;
                    s_next.cnt         = '0;
                    s_next.status      = 1'b0;
                    s_next.flash_erase = 1'b1;
                    s_next.flash_addr  = sec_base;
                  end else begin
                    // R12 refused erase reads as failed
                    s_next.status = 1'b1;
                  end
                end
                MODE_LOCK: begin
                  // R17 permanent lock
                  if (!in_tool && !in_emu) begin
                    s_next.lock = 1'b1;
                  end
                end
                default: begin
                end
              endcase
            end
          end
        end
        OFS_SEC_HI: begin
          s_next.sec_hi = wbyte;
        end
        OFS_SEC_LO: begin
          // R22 only bit 7 kept
          s_next.sec_lo = wbyte[SEC_LO_BIT];
        end
        OFS_TBL_ADDR: begin
          s_next.tbl_addr = hwdata[15:0];
          if (s_reg.state == ST_IDLE) begin
            s_next.flash_addr = hwdata[15:0];
          end
        end
        OFS_TBL_WDATA: begin
          // R15 R14 R23 byte program gate
          if (user_ok && s_reg.mode == MODE_PROG && s_reg.state == ST_IDLE
              && same_sector && !addr_prot) begin
            s_next.flash_prog  = 1'b1;
            s_next.flash_wdata = wbyte;
            s_next.flash_addr  = s_reg.tbl_addr;
          end
        end
        default: begin
        end
      endcase
    end

    // ****************
    // Erase sequencer
    // ****************
    case (s_reg.state)
      ST_IDLE: begin
      end
      ST_ERASE: begin
        s_next.cnt = s_reg.cnt + 1'b1;
        if (irq_request) begin
          // R20 abort leaves failure flag
          s_next.status      = 1'b1;
          s_next.state       = ST_IDLE;
          s_next.flash_erase = 1'b0;
          s_next.flash_addr  = s_reg.tbl_addr;
        // R10 full erase time
        end else if (s_reg.cnt == ERASE_LAST) begin
          s_next.status      = 1'b0;
          s_next.state       = ST_IDLE;
          s_next.flash_erase = 1'b0;
          s_next.flash_addr  = s_reg.tbl_addr;
        end
      end
      default: begin
        s_next.state       = ST_IDLE;
        s_next.flash_erase = 1'b0;
      end
    endcase

    // R18 lock cleared by tool chip erase only
    if (chip_erase && in_tool) begin
      s_next.lock = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg <= CTRL_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // ****************
  // Outputs
  // ****************
  assign hrdata       = s_reg.hrdata;
  assign hreadyout    = s_reg.hreadyout;
  assign hresp        = 1'b0;
  assign flash_addr   = s_reg.flash_addr;
  assign flash_wdata  = s_reg.flash_wdata;
  assign flash_prog   = s_reg.flash_prog;
  assign flash_erase  = s_reg.flash_erase;
  assign reset_vector = s_reg.reset_vector;
  assign lock_active  = s_reg.lock;
  assign erase_busy   = (s_reg.state == ST_ERASE);

endmodule

// file: verification/flash_ctrl_asserts.sv
// Port-level assertions for the user-mode flash controller
module flash_ctrl_asserts
  import flash_prog_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic [7:0]  option_byte,
  input wire logic        tool_mode,
  input wire logic        irq_request,
  input wire logic        chip_erase,
  input wire logic [15:0] flash_addr,
  input wire logic        flash_prog,
  input wire logic        flash_erase,
  input wire logic [15:0] reset_vector,
  input wire logic        lock_active,
  input wire logic        erase_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] rend;
  logic [15:0] vexp;
  always_comb begin
    rend = option_byte[1] ? (option_byte[0] ? REGION_END3 : REGION_END2)
                          : (option_byte[0] ? REGION_END1 : REGION_END0);
    vexp = option_byte[6] ? (option_byte[5] ? VEC_SEL3 : VEC_SEL2)
                          : (option_byte[5] ? VEC_SEL1 : VEC_SEL0);
    if (option_byte[7]) vexp = VEC_DEFAULT;
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ****************
  // Checks
  // ****************
  chk_erase_strobe: assert property (flash_erase == erase_busy)
    else $error("erase strobe differs from busy");
  chk_irq_abort: assert property (erase_busy && irq_request |=> !erase_busy)
    else $error("erase not aborted");
  chk_prog_pulse: assert property (flash_prog |-> !erase_busy ##1 !flash_prog)
    else $error("program pulse too long");
  chk_lock_blocks: assert property (lock_active && $past(lock_active)
    |-> !flash_prog && !$rose(erase_busy)) else $error("write while locked");
  chk_lock_sticky: assert property (lock_active && !chip_erase |=> lock_active)
    else $error("lock lost");
  chk_tool_noerase: assert property (tool_mode[*4] |-> !$rose(erase_busy))
    else $error("erase in tool mode");
  chk_region_safe: assert property (flash_prog && !option_byte[2] && !tool_mode
    |-> !(flash_addr >= REGION_BASE && flash_addr <= rend)) else $error("region hit");
  chk_vec_decode: assert property ($stable(option_byte)[*5] |-> reset_vector == vexp)
    else $error("reset vector wrong");
  cov_erase: cover property ($rose(erase_busy));
  cov_prog: cover property (flash_prog);
  cov_lock: cover property ($rose(lock_active));
endmodule

// file: verification/flash_array_model.sv
// Behavioural flash array seen by the controller
module flash_array_model
(
  input wire logic        hclk,
  input wire logic [15:0] flash_addr,
  input wire logic [7:0]  flash_wdata,
  input wire logic        flash_prog,
  input wire logic        flash_erase,
  output logic     [7:0]  flash_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:65535];
  initial for (int i = 0; i < 65536; i++) mem[i] = 8'hff;
  assign flash_rdata = mem[flash_addr];
  always @(posedge hclk) begin
    if (flash_erase === 1'b1)
      for (int i = 0; i < 128; i++) mem[{flash_addr[15:7], 7'(i)}] <= 8'hff;
    // cells only clear, so skipping erase corrupts data
    if (flash_prog === 1'b1) mem[flash_addr] <= mem[flash_addr] & flash_wdata;
  end
endmodule

// file: verification/flash_user_program_ctrl_tb_top.sv
// Self-checking bench for the user-mode flash controller
module flash_user_program_ctrl_tb_top import flash_prog_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int EC = 20;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, rv = 0;
  logic        tool = 0, emu = 0, irq = 0, cer = 0, hreadyout, hresp;
  logic        flash_prog, flash_erase, lock_active, erase_busy;
  logic [1:0]  htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata;
  logic [7:0]  opt, d, flash_rdata, flash_wdata;
  logic [15:0] a, vexp, rend, flash_addr, reset_vector;
  logic [15:0] vtab [4] = '{VEC_SEL0, VEC_SEL1, VEC_SEL2, VEC_SEL3};
  logic [15:0] rtab [4] = '{REGION_END0, REGION_END1, REGION_END2, REGION_END3};
  logic [31:0] q [$];
  int          fail_count = 0, check_count = 0, run = 0, last = 0;
  always #2.5 hclk = ~hclk;
  flash_user_program_ctrl #(.ERASE_CYCLES(EC)) dut_u (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
    .hresp, .option_byte(opt), .tool_mode(tool), .emulator_mode(emu), .irq_request(irq),
    .chip_erase(cer), .flash_rdata, .flash_addr, .flash_wdata, .flash_prog, .flash_erase,
    .reset_vector, .lock_active, .erase_busy);
  flash_array_model mdl_u (.hclk, .flash_addr, .flash_wdata, .flash_prog, .flash_erase,
    .flash_rdata);
  // ****************
  // Bus and helpers
  // ****************
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    hsel <= 1;
    haddr <= {24'h00_0000, ad};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 0;
    htrans <= 2'b00;
    hwdata <= wd;
    rv <= !w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rv <= 0;
    @(posedge hclk);
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
    xfer(1, ad, wd);
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] e);
    q.push_back(e);
    xfer(0, ad, 0);
  endtask
  always @(posedge hclk) begin
    if (rv === 1'b1) begin
      cmp(hrdata, q.pop_front());
      cmp(32'(hresp), 32'h0000_0000);
    end
  end
  always @(posedge hclk) begin
    if (erase_busy === 1'b1) run <= run + 1;
    else begin
      if (run != 0) last <= run;
      run <= 0;
    end
  end
  task automatic sec(input logic [15:0] s);
    wr(OFS_SEC_HI, 32'(s[15:8]));
    wr(OFS_SEC_LO, 32'(s[7:0] | 8'h7f));
  endtask
  task automatic erase(input logic [15:0] s);
    wr(OFS_UNLOCK, 32'(UNLOCK_KEY));
    sec(s);
    wr(OFS_OPCTL, 32'h0000_00a1);
    repeat (2) @(posedge hclk);
    wr(OFS_UNLOCK, 0);
  endtask
  task automatic prog(input logic [15:0] s, ad, input logic [7:0] v, k);
    wr(OFS_UNLOCK, 32'(k));
    wr(OFS_OPCTL, 32'h0000_0050);
    sec(s);
    wr(OFS_TBL_ADDR, 32'(ad));
    wr(OFS_TBL_WDATA, 32'(v));
    wr(OFS_UNLOCK, 0);
  endtask
  task automatic byte_is(input logic [15:0] ad, input logic [7:0] e);
    wr(OFS_TBL_ADDR, 32'(ad));
    rd(OFS_TBL_RDATA, 32'(e));
  endtask
  task automatic idle;
    for (int n = 0; n < 200 && erase_busy !== 1'b0; n++) @(negedge hclk);
    // Second edge lets the run length settle before it is read
    repeat (2) @(posedge hclk);
  endtask
  task automatic pulse_cer;
    cer <= 1;
    @(posedge hclk);
    cer <= 0;
    repeat (2) @(posedge hclk);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    fail_count++;
    end_sim();
  end
  // ****************
  // Tests
  // ****************
  initial begin
    void'($urandom(93685));
    opt = 8'($urandom);
    opt[2] = 1'b0;
    vexp = opt[7] ? VEC_DEFAULT : vtab[opt[6:5]];
    rend = rtab[opt[1:0]];
    a = 16'h1780 | 16'($urandom_range(127));
    d = 8'($urandom);
    repeat (6) @(posedge hclk);
    hresetn <= 1;
    repeat (5) @(posedge hclk);
    rd(OFS_UNLOCK, 0);
    rd(OFS_STATUS, {vexp, 16'h0004});
    prog(16'h1780, a, d, 8'ha4);
    byte_is(a, 8'hff);
    rd(OFS_TBL_ADDR, 32'(a));
    $display("test reset and key done");
    erase(16'h1780);
    rd(OFS_OPCTL, 32'h0000_00a1);
    idle();
    cmp(last, EC);
    rd(OFS_OPCTL, 32'h0000_00a0);
    rd(OFS_SEC_LO, 32'h0000_0080);
    rd(OFS_SEC_HI, 32'h0000_0017);
    prog(16'h1780, a, d, UNLOCK_KEY);
    prog(16'h1780, 16'h1800, 8'h00, UNLOCK_KEY);
    byte_is(a, d);
    byte_is(16'h1800, 8'hff);
    $display("test erase and program done");
    erase(16'h1780);
    irq <= 1;
    @(posedge hclk);
    irq <= 0;
    idle();
    rd(OFS_OPCTL, 32'h0000_00a8);
    erase(16'h1780);
    idle();
    byte_is(a, 8'hff);
    $display("test abort done");
    erase(rend & 16'hff80);
    idle();
    rd(OFS_OPCTL, 32'h0000_00a8);
    erase(rend + 16'h0001);
    idle();
    rd(OFS_OPCTL, 32'h0000_00a0);
    prog(REGION_BASE, REGION_BASE, 8'h00, UNLOCK_KEY);
    byte_is(REGION_BASE, 8'hff);
    opt[2] <= 1'b1;
    repeat (5) @(posedge hclk);
    prog(REGION_BASE, REGION_BASE, 8'h00, UNLOCK_KEY);
    byte_is(REGION_BASE, 8'h00);
    $display("test region done");
    tool <= 1;
    repeat (4) @(posedge hclk);
    erase(16'h1000);
    idle();
    rd(OFS_OPCTL, 32'h0000_00a8);
    tool <= 0;
    emu <= 1;
    repeat (4) @(posedge hclk);
    erase(16'h1000);
    rd(OFS_OPCTL, 32'h0000_00a8);
    emu <= 0;
    repeat (4) @(posedge hclk);
    $display("test tool mode done");
    wr(OFS_UNLOCK, 32'(UNLOCK_KEY));
    wr(OFS_OPCTL, 32'h0000_0061);
    repeat (2) @(posedge hclk);
    wr(OFS_UNLOCK, 0);
    rd(OFS_STATUS, {vexp, 16'h0001});
    prog(16'h1780, a, 8'h00, UNLOCK_KEY);
    byte_is(a, 8'hff);
    pulse_cer();
    rd(OFS_STATUS, {vexp, 16'h0001});
    tool <= 1;
    repeat (4) @(posedge hclk);
    pulse_cer();
    rd(OFS_STATUS, {vexp, 16'h0000});
    $display("test lock done");
    end_sim();
  end
endmodule
bind flash_user_program_ctrl flash_ctrl_asserts chk_u (.hclk, .hresetn, .option_byte,
  .tool_mode, .irq_request, .chip_erase, .flash_addr, .flash_prog, .flash_erase,
  .reset_vector, .lock_active, .erase_busy);
